// ==== logic/csrw_top.v ====
// Purpose: Strap capture, soft-reset control and watchdog for the CPU subsystem
// Assumes: AHB-Lite single word transfers; inputs synchronous to hclk
// Notes: Subsystem clocks come from an outside PLL; this block only paces resets
`include "csrw_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - General control reset value comes from four straps sampled after reset release.
// - Strap 0000 LE flash boot, 1100 BE flash boot, 1111 host boot.
// - Serial slave is disabled while the serial boot owner bit is set.
// - CPU endianness follows the big endian enable bit.
// - Clearing the owner bit after boot re-enables the serial slave.
// - Setting mgmt slave enable turns the slave on and takes its pins.
// - JTAG goes to CPU debug when select low, boundary scan when high.
// - CPU at 500 MHz, DRAM controller 312.5 MHz, rest 250 MHz.
// - Force reset resets CPU and subsystem unless CPU-only is set.
// - With CPU-only set, only the CPU is reset.
// - Switch register bus slaves are untouched by subsystem soft reset.
// - Chip soft reset bit applies a chip-level soft reset.
// - With protect set, chip reset spares CPU and subsystem.
// - Switch-core soft reset leaves SERDES and PLL unreset.
// - Scratch and pin alternate registers clear only on external reset.
// - Watchdog: two-second timeout, off after reset, controlled by its register.
// - Watchdog expiry acts like force reset, honouring CPU-only.
// - Lock field misuse triggers an immediate watchdog reset.
// - Reset cause shows watchdog or regular, updated only at CPU reset.
module csrw_top #(
  parameter [7:0] WD_LOCK_KEY = 8'hA5,
  parameter integer WD_CYCLES = `CSRW_WD_TIMEOUT_MS * `CSRW_HCLK_KHZ,
  parameter integer RST_CYCLES = `CSRW_RST_PULSE,
  parameter integer ALT_W = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  input wire [3:0] strap_cfg,
  input wire jtag_target_select_n,
  output reg jtag_to_cpu_debug,
  output reg jtag_to_bscan,
  output reg cpu_run_enable,
  output reg cpu_big_endian,
  output reg flash_boot_map,
  output reg serial_slave_enable,
  output reg mgmt_slave_on,
  output reg mgmt_slave_addr31,
  output reg mgmt_pins_take,
  output reg pcie_enable,
  output reg cpu_soft_reset,
  output reg subsys_soft_reset,
  output reg chip_soft_reset,
  output reg serdes_pll_soft_reset,
  output reg wd_timeout_pulse,
  output reg [ALT_W-1:0] pin_alternate_mode
);

  localparam integer WD_W = 32;
  localparam integer RC_W = 8;
  // Clock ratios the outside PLL must honour; reset pulse covers slowest domain
  localparam integer SYS_PER_HCLK = `CSRW_SYS_CLK_KHZ / `CSRW_HCLK_KHZ;
  localparam integer CPU_PER_HCLK = `CSRW_CPU_CLK_KHZ / `CSRW_HCLK_KHZ;
  localparam integer DDR_PER_HCLK = `CSRW_DDR_CLK_KHZ / `CSRW_HCLK_KHZ;

  function [`CSRW_GC_W-1:0] strap_decode;
    input [3:0] code;
    begin
      // Reserved codes fall back to host mode, so a bad strap never starts the CPU
      strap_decode = `CSRW_GC_PRESTRAP;
      case (code)
        `CSRW_STRAP_LE_FLASH: begin
          strap_decode[`CSRW_GC_OWNER] = 1'b1;
          strap_decode[`CSRW_GC_BOOT] = 1'b1;
          strap_decode[`CSRW_GC_DIS] = 1'b0;
        end
        `CSRW_STRAP_BE_FLASH: begin
          strap_decode[`CSRW_GC_OWNER] = 1'b1;
          strap_decode[`CSRW_GC_BOOT] = 1'b1;
          strap_decode[`CSRW_GC_BE] = 1'b1;
          strap_decode[`CSRW_GC_DIS] = 1'b0;
        end
        `CSRW_STRAP_PCIE: begin
          strap_decode[`CSRW_GC_PCIE] = 1'b1;
        end
        `CSRW_STRAP_MGMT0: begin
          strap_decode[`CSRW_GC_MGMT] = 1'b1;
        end
        `CSRW_STRAP_MGMT31: begin
          strap_decode[`CSRW_GC_MGMT] = 1'b1;
          strap_decode[`CSRW_GC_MADDR] = 1'b1;
        end
        `CSRW_STRAP_HOST: strap_decode = `CSRW_GC_PRESTRAP;
        default: strap_decode = `CSRW_GC_PRESTRAP;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  reg [`CSRW_GC_W-1:0] gen_r;
  reg [2:0] rst_ctl_r;
  reg [3:0] strap_lat_r;
  reg strap_done_r;
  reg [3:0] strap_cnt_r;
  reg wd_en_r;
  reg wd_cause_r;
  reg [31:0] scratch_r [0:3];
  reg [31:0] rd_nxt;
  reg rst_active_r;

  wire take = hsel & hready & htrans[1];
  wire [7:0] a_ofs = {haddr[7:2], 2'b00};
  wire [7:0] wofs = wr_addr_r;
  wire wr_gen = wr_pend_r & (wofs == `CSRW_OFS_GEN_CTRL);
  wire wr_rst = wr_pend_r & (wofs == `CSRW_OFS_RESET);
  wire wr_srst = wr_pend_r & (wofs == `CSRW_OFS_SOFT_RST);
  wire wr_wd = wr_pend_r & (wofs == `CSRW_OFS_WDOG);
  wire wr_alt = wr_pend_r & (wofs == `CSRW_OFS_PIN_ALT);
  wire wr_scr = wr_pend_r & (wofs >= `CSRW_OFS_SCRATCH0) & (wofs <= `CSRW_OFS_SCRATCH3);

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (a_ofs)
      `CSRW_OFS_GEN_CTRL: rd_nxt[`CSRW_GC_W-1:0] = gen_r;
      `CSRW_OFS_RESET: rd_nxt[2:0] = rst_ctl_r;
      // Reset triggers are pulses; reading them back gives zero
      `CSRW_OFS_SOFT_RST: rd_nxt = 32'h0000_0000;
      `CSRW_OFS_WDOG: begin
        rd_nxt[`CSRW_WD_EN] = wd_en_r;
        rd_nxt[`CSRW_WD_CAUSE] = wd_cause_r;
      end
      `CSRW_OFS_SCRATCH0: rd_nxt = scratch_r[0];
      `CSRW_OFS_SCRATCH1: rd_nxt = scratch_r[1];
      `CSRW_OFS_SCRATCH2: rd_nxt = scratch_r[2];
      `CSRW_OFS_SCRATCH3: rd_nxt = scratch_r[3];
      `CSRW_OFS_PIN_ALT: rd_nxt[ALT_W-1:0] = pin_alternate_mode;
      `CSRW_OFS_STATUS: rd_nxt[5:0] = {rst_active_r, strap_done_r, strap_lat_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      // Zero wait states; unmapped reads return zero, writes are dropped
      wr_pend_r <= take & hwrite;
      if (take) begin
        wr_addr_r <= a_ofs;
      end
      if (take & ~hwrite) begin
        hrdata <= rd_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strap capture and general control
  wire core_start;
  wire chip_start;
  wire cpu_start;
  wire chip_unprot = chip_start & ~rst_ctl_r[`CSRW_RST_PROTECT];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_cnt_r <= 4'h0;
      strap_done_r <= 1'b0;
      strap_lat_r <= 4'h0;
      gen_r <= `CSRW_GC_PRESTRAP;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 4'h1;
      if (strap_cnt_r == `CSRW_STRAP_DLY) begin
        strap_done_r <= 1'b1;
        strap_lat_r <= strap_cfg;
        gen_r <= strap_decode(strap_cfg);
      end
    end else if (chip_unprot) begin
      gen_r <= strap_decode(strap_lat_r);
    end else if (wr_gen) begin
      // Host boot sequences are plain writes of these fields
      gen_r <= hwdata[`CSRW_GC_W-1:0];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_run_enable <= 1'b0;
      cpu_big_endian <= 1'b0;
      flash_boot_map <= 1'b0;
    end else begin
      // CPU stays off until straps are known
      cpu_run_enable <= strap_done_r & ~gen_r[`CSRW_GC_DIS] & ~cpu_soft_reset;
      cpu_big_endian <= gen_r[`CSRW_GC_BE];
      flash_boot_map <= gen_r[`CSRW_GC_BOOT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slave ownership; these sit on the switch register bus, outside subsystem resets
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_slave_enable <= 1'b0;
      mgmt_slave_on <= 1'b0;
      mgmt_slave_addr31 <= 1'b0;
      mgmt_pins_take <= 1'b0;
      pcie_enable <= 1'b0;
    end else begin
      serial_slave_enable <= ~gen_r[`CSRW_GC_OWNER];
      mgmt_slave_on <= gen_r[`CSRW_GC_MGMT];
      mgmt_slave_addr31 <= gen_r[`CSRW_GC_MADDR];
      mgmt_pins_take <= gen_r[`CSRW_GC_MGMT];
      pcie_enable <= gen_r[`CSRW_GC_PCIE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared JTAG pins; neither controller owns them in reset, exactly one from the first clock after it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jtag_to_cpu_debug <= 1'b0;
      jtag_to_bscan <= 1'b0;
    end else begin
      jtag_to_cpu_debug <= ~jtag_target_select_n;
      jtag_to_bscan <= jtag_target_select_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scratch and pin alternate settings: external reset only
  integer i;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        scratch_r[i] <= 32'h0000_0000;
      end
      pin_alternate_mode <= {ALT_W{1'b0}};
    end else begin
      if (wr_scr) begin
        scratch_r[wofs[3:2]] <= hwdata;
      end
      if (wr_alt) begin
        pin_alternate_mode <= hwdata[ALT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  reg [WD_W-1:0] wd_cnt_r;
  reg wd_hit_r;
  wire [7:0] wd_lock = hwdata[`CSRW_WD_LOCK_LSB +: `CSRW_WD_LOCK_W];
  wire wd_req_en = wr_wd & hwdata[`CSRW_WD_EN];
  wire wd_good = wd_req_en & (wd_lock == WD_LOCK_KEY);
  wire wd_misuse = wd_req_en & (wd_lock != WD_LOCK_KEY);
  wire wd_expire = wd_en_r & (wd_cnt_r == WD_CYCLES - 1);
  wire wd_fire = wd_expire | wd_misuse;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_en_r <= 1'b0;
      wd_cnt_r <= {WD_W{1'b0}};
      wd_hit_r <= 1'b0;
      wd_cause_r <= 1'b0;
      wd_timeout_pulse <= 1'b0;
    end else begin
      wd_timeout_pulse <= wd_fire;
      if (cpu_start) begin
        // Cause latched only as a CPU reset begins; a fresh hit this cycle counts
        wd_cause_r <= wd_hit_r | wd_fire;
        wd_hit_r <= 1'b0;
        wd_en_r <= 1'b0;
        wd_cnt_r <= {WD_W{1'b0}};
      end else begin
        if (wd_fire) begin
          wd_hit_r <= 1'b1;
        end
        if (wd_fire | (wr_wd & ~hwdata[`CSRW_WD_EN])) begin
          wd_en_r <= 1'b0;
          wd_cnt_r <= {WD_W{1'b0}};
        end else if (wd_good) begin
          wd_en_r <= 1'b1;
          wd_cnt_r <= {WD_W{1'b0}};
        end else if (wd_en_r) begin
          wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Soft-reset sequencer
  reg [RC_W-1:0] rst_cnt_r;
  wire cpu_only = rst_ctl_r[`CSRW_RST_CPU_ONLY];
  wire protect = rst_ctl_r[`CSRW_RST_PROTECT];
  wire force_wr = wr_rst & hwdata[`CSRW_RST_FORCE];
  wire chip_wr = wr_srst & hwdata[`CSRW_SRST_CHIP];
  wire swc_wr = wr_srst & hwdata[`CSRW_SRST_SWC] & ~hwdata[`CSRW_SRST_CHIP];
  assign core_start = force_wr | wd_fire;
  // Protected chip resets never touch the CPU, so its run state survives them
  assign chip_start = chip_wr | swc_wr;
  assign cpu_start = core_start | (chip_start & ~protect);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_ctl_r <= 3'b000;
    end else if (chip_unprot) begin
      rst_ctl_r <= 3'b000;
    end else if (wr_rst) begin
      // Force bit is a trigger, never stored
      rst_ctl_r <= {hwdata[`CSRW_RST_PROTECT], hwdata[`CSRW_RST_CPU_ONLY], 1'b0};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_cnt_r <= {RC_W{1'b0}};
      rst_active_r <= 1'b0;
      cpu_soft_reset <= 1'b0;
      subsys_soft_reset <= 1'b0;
      chip_soft_reset <= 1'b0;
      serdes_pll_soft_reset <= 1'b0;
    end else if (core_start | chip_start) begin
      // New requests merge into an active pulse and restart its length
      rst_cnt_r <= RST_CYCLES[RC_W-1:0];
      rst_active_r <= 1'b1;
      if (cpu_start) begin
        cpu_soft_reset <= 1'b1;
      end
      if ((core_start & ~cpu_only) | (chip_start & ~protect)) begin
        subsys_soft_reset <= 1'b1;
      end
      if (chip_start) begin
        chip_soft_reset <= 1'b1;
      end
      if (chip_wr) begin
        serdes_pll_soft_reset <= 1'b1;
      end
    end else if (rst_active_r) begin
      if (rst_cnt_r == {RC_W{1'b0}}) begin
        rst_active_r <= 1'b0;
        cpu_soft_reset <= 1'b0;
        subsys_soft_reset <= 1'b0;
        chip_soft_reset <= 1'b0;
        serdes_pll_soft_reset <= 1'b0;
      end else begin
        rst_cnt_r <= rst_cnt_r - {{(RC_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // csrw_top

// ==== logic/csrw_defs.vh ====
// Purpose: Constants for the CPU subsystem reset and watchdog block
// Assumes: Included by csrw_top.v and by the testbench
// Notes: Byte offsets on a 32-bit AHB-Lite slave
`ifndef CSRW_DEFS_VH
`define CSRW_DEFS_VH

// Register byte offsets
`define CSRW_OFS_GEN_CTRL 8'h00
`define CSRW_OFS_RESET 8'h04
`define CSRW_OFS_SOFT_RST 8'h08
`define CSRW_OFS_WDOG 8'h0C
`define CSRW_OFS_SCRATCH0 8'h10
`define CSRW_OFS_SCRATCH1 8'h14
`define CSRW_OFS_SCRATCH2 8'h18
`define CSRW_OFS_SCRATCH3 8'h1C
`define CSRW_OFS_PIN_ALT 8'h20
`define CSRW_OFS_STATUS 8'h24

// General control fields
`define CSRW_GC_W 7
`define CSRW_GC_OWNER 0
`define CSRW_GC_BOOT 1
`define CSRW_GC_DIS 2
`define CSRW_GC_BE 3
`define CSRW_GC_MGMT 4
`define CSRW_GC_MADDR 5
`define CSRW_GC_PCIE 6
// Value before straps are sampled: CPU held off, serial slave on
`define CSRW_GC_PRESTRAP 7'h04

// Strap codes
`define CSRW_STRAP_LE_FLASH 4'h0
`define CSRW_STRAP_PCIE 4'h9
`define CSRW_STRAP_MGMT0 4'hA
`define CSRW_STRAP_MGMT31 4'hB
`define CSRW_STRAP_BE_FLASH 4'hC
`define CSRW_STRAP_HOST 4'hF
`define CSRW_STRAP_DLY 4'h4

// Reset control fields
`define CSRW_RST_FORCE 0
`define CSRW_RST_CPU_ONLY 1
`define CSRW_RST_PROTECT 2
`define CSRW_SRST_CHIP 0
`define CSRW_SRST_SWC 1

// Watchdog fields
`define CSRW_WD_LOCK_LSB 0
`define CSRW_WD_LOCK_W 8
`define CSRW_WD_EN 8
`define CSRW_WD_CAUSE 9

// Timing
`define CSRW_HCLK_KHZ 25000
`define CSRW_WD_TIMEOUT_MS 2000
`define CSRW_CPU_CLK_KHZ 500000
`define CSRW_DDR_CLK_KHZ 312500
`define CSRW_SYS_CLK_KHZ 250000
`define CSRW_RST_PULSE 16

`endif

// ==== tb/csrw_top_props.sv ====
// Purpose: Assertions on reset, watchdog and jtag outputs
// Assumes: Bound to csrw_top, one clock domain
// Notes: Reset length measured by a local counter
module csrw_props #(
  parameter integer RST_CYCLES = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire jtag_target_select_n,
  input wire jtag_to_cpu_debug,
  input wire jtag_to_bscan,
  input wire cpu_run_enable,
  input wire cpu_soft_reset,
  input wire subsys_soft_reset,
  input wire chip_soft_reset,
  input wire serdes_pll_soft_reset,
  input wire wd_timeout_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cpu_len_r;
  logic [7:0] cpu_len_nxt;
  assign cpu_len_nxt = cpu_soft_reset ? cpu_len_r + 8'h01 : 8'h00;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cpu_len_r <= 8'h00;
    else cpu_len_r <= cpu_len_nxt;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  chk_jtag_route: assert property ($past(hresetn) |->
    jtag_to_cpu_debug == !$past(jtag_target_select_n) && jtag_to_bscan != jtag_to_cpu_debug)
    else $error("jtag routing wrong");
  chk_cpu_hold: assert property (cpu_soft_reset ##1 cpu_soft_reset |-> !cpu_run_enable)
    else $error("cpu runs during its reset");
  chk_rst_len: assert property ($fell(cpu_soft_reset) |-> cpu_len_r == RST_CYCLES + 1)
    else $error("cpu reset length wrong");
  chk_chip_len: assert property ($rose(chip_soft_reset) |-> chip_soft_reset [*8])
    else $error("chip reset too short");
  chk_subsys_cpu: assert property (subsys_soft_reset |-> cpu_soft_reset)
    else $error("subsystem reset without cpu");
  chk_serdes_chip: assert property (serdes_pll_soft_reset |-> chip_soft_reset)
    else $error("serdes reset outside chip reset");
  chk_wd_reset: assert property (wd_timeout_pulse |-> ##[0:1] cpu_soft_reset)
    else $error("watchdog fire without cpu reset");
  chk_wd_pulse: assert property (wd_timeout_pulse |=> !wd_timeout_pulse)
    else $error("watchdog pulse too long");
endmodule // csrw_props

bind csrw_top csrw_props #(.RST_CYCLES(RST_CYCLES)) u_props (.hclk(hclk), .hresetn(hresetn),
  .jtag_target_select_n(jtag_target_select_n), .jtag_to_cpu_debug(jtag_to_cpu_debug),
  .jtag_to_bscan(jtag_to_bscan), .cpu_run_enable(cpu_run_enable), .cpu_soft_reset(cpu_soft_reset),
  .subsys_soft_reset(subsys_soft_reset), .chip_soft_reset(chip_soft_reset),
  .serdes_pll_soft_reset(serdes_pll_soft_reset), .wd_timeout_pulse(wd_timeout_pulse));

// ==== tb/csrw_host.sv ====
// Purpose: AHB-Lite host model, single word transfers
// Assumes: One slave, its hreadyout is hready
// Notes: Released lines are scrambled, not held
module csrw_host (
  input wire hclk,
  input wire hreadyout,
  input wire [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rd_val;
  event rd_done;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    hung = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic beat();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      @(posedge hclk);
      n++;
    end
    if (n == 20) hung = 1'b1;
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    beat();
    hsel <= 1'b0;
    htrans <= 2'b00;
    haddr <= ~a;
    hwdata <= w ? d : ~hwdata;
    beat();
    hwdata <= ~hwdata;
    if (!w) begin
      rd_val = hrdata;
      ->rd_done;
    end
  endtask
endmodule // csrw_host

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for csrw_top
// Assumes: Short watchdog count of 64 cycles
// Notes: Reads are checked against a queue of notes
`include "csrw_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [7:0] WD_KEY = 8'hA5; // Arbitrary lock value
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [3:0] strap_cfg = 4'h0;
  logic jtag_target_select_n = 1'b0;
  wire hsel, hwrite, hreadyout, hresp, host_hung, jtag_to_cpu_debug, jtag_to_bscan, cpu_run_enable;
  wire cpu_big_endian, flash_boot_map, serial_slave_enable, mgmt_slave_on, mgmt_slave_addr31, mgmt_pins_take;
  wire pcie_enable, cpu_soft_reset, subsys_soft_reset, chip_soft_reset, serdes_pll_soft_reset, wd_timeout_pulse;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [15:0] pin_alternate_mode;
  int err_count = 0;
  int compares = 0;
  int pulses = 0;
  logic [31:0] expq[$];
  logic [31:0] sd;
  always #20 hclk = ~hclk;
  csrw_host host (.hclk, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hung(host_hung));
  csrw_top #(.WD_LOCK_KEY(WD_KEY), .WD_CYCLES(64), .RST_CYCLES(16), .ALT_W(16)) dut (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .strap_cfg,
    .jtag_target_select_n, .jtag_to_cpu_debug, .jtag_to_bscan, .cpu_run_enable, .cpu_big_endian,
    .flash_boot_map, .serial_slave_enable, .mgmt_slave_on, .mgmt_slave_addr31, .mgmt_pins_take, .pcie_enable,
    .cpu_soft_reset, .subsys_soft_reset, .chip_soft_reset, .serdes_pll_soft_reset, .wd_timeout_pulse,
    .pin_alternate_mode);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer({24'h00_0000, a}, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    host.xfer({24'h00_0000, a}, 1'b0, 32'h0000_0000);
  endtask
  task automatic settle();
    @(posedge hclk);
    #1;
  endtask
  task automatic ext_reset(input logic [3:0] s);
    @(posedge hclk);
    hresetn <= 1'b0;
    strap_cfg <= s;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    strap_cfg <= ~s; // Pins reused after capture
  endtask
  task automatic gen_ports(input logic [6:0] g);
    chk({25'h000_0000, pcie_enable, mgmt_slave_addr31, mgmt_slave_on, mgmt_pins_take, cpu_big_endian,
      flash_boot_map, serial_slave_enable}, {25'h000_0000, g[6:4], g[4:3], g[1], ~g[0]});
    chk({31'h0000_0000, cpu_run_enable}, {31'h0000_0000, ~g[2]});
  endtask
  task automatic rchk(input logic [3:0] e);
    settle();
    chk({28'h000_0000, chip_soft_reset, serdes_pll_soft_reset, cpu_soft_reset, subsys_soft_reset}, e);
  endtask
  task automatic wait_pulse(input int lim);
    int n;
    n = 0;
    while (wd_timeout_pulse !== 1'b1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
    if (n == lim) begin
      chk(32'h0000_0000, 32'h0000_0001);
      summarize();
    end
  endtask
  always @(host.rd_done) chk(host.rd_val, expq.pop_front());
  always @(posedge hclk) if (wd_timeout_pulse === 1'b1) pulses++;
  always @(posedge hclk) if (host_hung === 1'b1) begin
    err_count++;
    summarize();
  end
  initial begin
    #500us;
    err_count++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] codes[6];
    logic [6:0] gens[6];
    codes = '{4'h0, 4'hC, 4'h9, 4'hA, 4'hB, 4'hF};
    gens = '{7'h03, 7'h0B, 7'h44, 7'h14, 7'h34, 7'h04};
    void'($urandom(60));
    sd = $urandom;
    for (int i = 0; i < 6; i++) begin
      ext_reset(codes[i]);
      settle();
      gen_ports(gens[i]);
      rd(`CSRW_OFS_GEN_CTRL, {25'h000_0000, gens[i]});
      rd(`CSRW_OFS_STATUS, {27'h000_0000, 1'b1, codes[i]});
      $display("strap %h done", codes[i]);
    end
    wr(`CSRW_OFS_GEN_CTRL, 32'h0000_0003);
    settle();
    gen_ports(7'h03);
    wr(`CSRW_OFS_GEN_CTRL, 32'h0000_0010);
    settle();
    gen_ports(7'h10);
    wr(`CSRW_OFS_SCRATCH0, sd);
    wr(`CSRW_OFS_PIN_ALT, sd);
    $display("boot control done");
    rd(`CSRW_OFS_WDOG, 32'h0000_0000);
    repeat (3) begin
      wr(`CSRW_OFS_WDOG, {24'h00_0001, WD_KEY});
      rd(`CSRW_OFS_WDOG, 32'h0000_0100);
      repeat (36) @(posedge hclk);
    end
    repeat (22) @(posedge hclk);
    chk(pulses, 0);
    wait_pulse(20);
    rchk(4'h3);
    repeat (20) @(posedge hclk);
    rd(`CSRW_OFS_WDOG, 32'h0000_0200);
    // Frame DMA taken as idle before every soft reset
    wr(`CSRW_OFS_RESET, 32'h0000_0002);
    wr(`CSRW_OFS_WDOG, 32'h0000_015A);
    wait_pulse(4);
    rchk(4'h2);
    repeat (20) @(posedge hclk);
    wr(`CSRW_OFS_RESET, 32'h0000_0000);
    wr(`CSRW_OFS_RESET, 32'h0000_0001);
    rchk(4'h3);
    chk({30'h0000_0000, serial_slave_enable, mgmt_slave_on}, 32'h0000_0003);
    repeat (20) @(posedge hclk);
    rd(`CSRW_OFS_WDOG, 32'h0000_0000);
    $display("watchdog done");
    wr(`CSRW_OFS_RESET, 32'h0000_0004);
    wr(`CSRW_OFS_SOFT_RST, 32'h0000_0001);
    rchk(4'hC);
    repeat (20) @(posedge hclk);
    wr(`CSRW_OFS_SOFT_RST, 32'h0000_0002);
    rchk(4'h8);
    repeat (20) @(posedge hclk);
    wr(`CSRW_OFS_RESET, 32'h0000_0000);
    wr(`CSRW_OFS_SOFT_RST, 32'h0000_0001);
    rchk(4'hF);
    repeat (20) @(posedge hclk);
    chk({16'h0000, pin_alternate_mode}, {16'h0000, sd[15:0]});
    rd(`CSRW_OFS_SCRATCH0, sd);
    rd(`CSRW_OFS_PIN_ALT, {16'h0000, sd[15:0]});
    rd(8'h3C, 32'h0000_0000);
    ext_reset(4'hF);
    rd(`CSRW_OFS_SCRATCH0, 32'h0000_0000);
    $display("soft resets done");
    for (int j = 0; j < 2; j++) begin
      @(posedge hclk);
      jtag_target_select_n <= j[0];
      settle();
      chk({30'h0000_0000, jtag_to_cpu_debug, jtag_to_bscan}, {30'h0000_0000, ~j[0], j[0]});
    end
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    $display("jtag done");
    summarize();
  end
endmodule // testbench
